//--- tcd_pkg.sv
package tcd_pkg;

    localparam int NCH = 2;
    localparam int AW  = 20;
    localparam int DW  = 16;
    localparam int CW  = 16;
    localparam int NPER = 15;

    ////////////////////////////////////////////////////////////////////
    // register map, byte offsets inside one channel window
    localparam logic [4:0] OFF_SEL = 5'h00;
    localparam logic [4:0] OFF_CTL = 5'h04;
    localparam logic [4:0] OFF_SRC = 5'h08;
    localparam logic [4:0] OFF_DST = 5'h0C;
    localparam logic [4:0] OFF_RLD = 5'h10;
    localparam logic [4:0] OFF_CNT = 5'h14;
    localparam logic [4:0] OFF_FWD = 5'h18;
    // address bit that picks channel 1 (window stride 0x20)
    localparam int ADDR_CH_BIT = 5;

    ////////////////////////////////////////////////////////////////////
    // field positions
    localparam int SEL_CAUSE_LSB = 0;
    localparam int SEL_EXT_BIT   = 6;
    localparam int SEL_SWREQ_BIT = 7;
    localparam int CTL_WORD_BIT  = 0;
    localparam int CTL_REP_BIT   = 1;
    localparam int CTL_EN_BIT    = 2;
    localparam int CTL_MODE_LSB  = 3;
    localparam int CTL_DONE_BIT  = 5;

    localparam logic [1:0] MODE_FIXED   = 2'h0;
    localparam logic [1:0] MODE_SRC_INC = 2'h1;
    localparam logic [1:0] MODE_DST_INC = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [3:0]    RST_CAUSE = 4'h0;
    localparam logic [1:0]    RST_MODE  = 2'h0;
    localparam logic [AW-1:0] RST_PTR   = 20'h00000;
    localparam logic [CW-1:0] RST_CNT   = 16'h0000;
    // pin sync stages start at the idle-high level: no edge after reset
    localparam logic [1:0]    RST_PINS  = 2'h3;

    ////////////////////////////////////////////////////////////////////
    // cause codes and peripheral request vector layout
    localparam logic [3:0] CAUSE_NONE      = 4'h0;
    localparam logic [3:0] CAUSE_OWN_INT   = 4'h1;
    localparam logic [3:0] CAUSE_TMR_FIRST = 4'h2;
    localparam logic [3:0] CAUSE_TMR_LAST  = 4'h9;
    localparam logic [3:0] CAUSE_UART0     = 4'hA;
    localparam logic [3:0] CAUSE_UART2     = 4'hC;
    localparam logic [3:0] CAUSE_ADC       = 4'hD;
    localparam logic [3:0] CAUSE_OTHER_INT = 4'hE;
    localparam logic [3:0] IDX_UART0       = 4'h8;
    localparam logic [3:0] IDX_UART1       = 4'hA;
    localparam logic [3:0] IDX_ADC         = 4'hE;

    typedef enum logic [2:0] {
        TCD_IDLE  = 3'b001,
        TCD_READ  = 3'b010,
        TCD_WRITE = 3'b100
    } tcd_fsm_t;

endpackage

//--- tcd_channel.sv
`timescale 1ns/1ns
module tcd_channel #(
    parameter bit CH          = 1'b0,
    parameter bit REDUCED_PKG = 1'b0
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    input  wire logic [3:0]              i_cause,
    input  wire logic                    i_ext,
    input  wire logic                    i_sw_req,
    input  wire logic                    i_enable,
    input  wire logic [tcd_pkg::NPER-1:0] i_periph,
    input  wire logic [1:0]              i_int_fall,
    input  wire logic [1:0]              i_int_both,
    input  wire logic                    i_taken,
    output logic                         o_pending
);

    typedef struct packed {
        logic pending;
    } tcd_chan_t;

    tcd_chan_t r;
    tcd_chan_t next_r;
    logic      hit;

    ////////////////////////////////////////////////////////////////////
    // cause decode; request flags are only sampled, never written [R6]
    always_comb
    begin
        logic [3:0] uidx;
        uidx = 4'h0;
        hit  = 1'b0;
        // channel index flips the edge and serial mapping [R12] [R11]
        unique case (i_cause)
            tcd_pkg::CAUSE_OWN_INT:
                hit = i_ext ? i_int_both[CH] : i_int_fall[CH];
            tcd_pkg::CAUSE_OTHER_INT:
                hit = i_ext ? i_int_both[!CH] : i_int_fall[!CH];
            tcd_pkg::CAUSE_ADC:
                hit = !i_ext && i_periph[tcd_pkg::IDX_ADC];
            default:
            begin
                if (i_cause >= tcd_pkg::CAUSE_TMR_FIRST &&
                    i_cause <= tcd_pkg::CAUSE_TMR_LAST)
                    hit = !i_ext &&
                          i_periph[i_cause - tcd_pkg::CAUSE_TMR_FIRST];
                else if (i_cause >= tcd_pkg::CAUSE_UART0 &&
                         i_cause <= tcd_pkg::CAUSE_UART2)
                begin
                    uidx = 4'((i_cause - tcd_pkg::CAUSE_UART0) << 1)
                         + tcd_pkg::IDX_UART0 + {3'h0, CH ^ i_ext};
                    // first serial port absent on small package [R19]
                    hit = i_periph[uidx] &&
                          !(REDUCED_PKG && uidx < tcd_pkg::IDX_UART1);
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // no mask or priority input: requests never see interrupt gating [R5]
    always_comb
    begin
        next_r = r;
        if (!i_enable)
            next_r.pending = 1'b0;                                  // [R7]
        else if (hit || i_sw_req)
            next_r.pending = 1'b1;                              // [R4] [R8]
        else if (i_taken)
            next_r.pending = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            r <= '0;
        else
            r <= next_r;
    end

    assign o_pending = r.pending;

    ////////////////////////////////////////////////////////////////////
    property p_dis_idle;
        @(posedge i_clk) disable iff (!i_nrst)
        !i_enable |=> !o_pending;
    endproperty
    a_dis_idle: assert property (p_dis_idle)                        // [R7]
        else $error("pending set while channel disabled");

    property p_sw_sets;
        @(posedge i_clk) disable iff (!i_nrst)
        i_enable && i_sw_req |=> o_pending;
    endproperty
    a_sw_sets: assert property (p_sw_sets)                      // [R4] [R8]
        else $error("software request lost");

endmodule

//--- tcd_dma.sv
//Behaviour
// R1: two independent cycle-stealing channels
// R2: one byte or word moved per request
// R3: controller takes bus before processor
// R4: software bit or selected interrupt requests
// R5: requests ignore interrupt masking
// R6: transfers never touch interrupt flags
// R7: requests start transfers only when enabled; pend drops a cycle after en, so a request still pending then can start one
// R8: fast requests may merge into one
// R9: src inc, dst inc or fixed; never both
// R10: counter allows up to 64K transfers
// R11: edge, timer, serial, converter, software causes
// R12: each channel has its own cause map
// R13: channel 0 served before channel 1
// R14: single mode ends on counter underflow
// R15: repeat mode reloads counter on underflow
// R16: single stops on disable/underflow, repeat on disable
// R17: first transfer reloads pointer and counter
// R18: software keeps channels off controller registers
// R19: small package lacks first serial causes
// R20: each transfer is read then write
// R21: pointer steps 1 or 2, counter minus one
`timescale 1ns/1ns
module tcd_dma #(
    parameter bit REDUCED_PKG = 1'b0
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_nrst,
    input  wire logic [5:0]               i_avs_address,
    input  wire logic                     i_avs_read,
    input  wire logic                     i_avs_write,
    input  wire logic [31:0]              i_avs_writedata,
    input  wire logic [3:0]               i_avs_byteenable,
    output logic      [31:0]              o_avs_readdata,
    output logic                          o_avs_waitrequest,
    input  wire logic [tcd_pkg::NPER-1:0] i_periph_irq,
    input  wire logic                     i_ext_irq_line_0,
    input  wire logic                     i_ext_irq_line_1,
    output logic                          o_cpu_hold,
    output logic      [tcd_pkg::AW-1:0]   o_mem_addr,
    output logic                          o_mem_read,
    output logic                          o_mem_write,
    output logic                          o_mem_word,
    output logic      [tcd_pkg::DW-1:0]   o_mem_wdata,
    input  wire logic [tcd_pkg::DW-1:0]   i_mem_rdata,
    input  wire logic                     i_mem_wait
);

    typedef struct packed {
        logic [1:0][3:0]             cause;
        logic [1:0]                  ext;
        logic [1:0]                  swreq;
        logic [1:0]                  word;
        logic [1:0]                  rep;
        logic [1:0]                  en;
        logic [1:0][1:0]             mode;
        logic [1:0]                  done;
        logic [1:0]                  first;
        logic [1:0][tcd_pkg::AW-1:0] src;
        logic [1:0][tcd_pkg::AW-1:0] dst;
        logic [1:0][tcd_pkg::AW-1:0] fwd;
        logic [1:0][tcd_pkg::CW-1:0] rld;
        logic [1:0][tcd_pkg::CW-1:0] cnt;
        tcd_pkg::tcd_fsm_t           fsm;
        logic                        ch;
        logic [tcd_pkg::AW-1:0]      mem_addr;
        logic                        mem_rd;
        logic                        mem_wr;
        logic                        mem_word;
        logic [tcd_pkg::DW-1:0]      mem_wdata;
        logic                        cpu_hold;
        logic                        wreq;
        logic [31:0]                 rdata;
        logic [1:0]                  s1;
        logic [1:0]                  s2;
        logic [1:0]                  s3;
    } tcd_state_t;

    tcd_state_t r;
    tcd_state_t next_r;
    logic [1:0] pend;
    logic [1:0] taken;
    logic [1:0] int_fall;
    logic [1:0] int_both;

    ////////////////////////////////////////////////////////////////////
    // register readback
    function automatic logic [31:0] reg_val(tcd_state_t s, logic c,
                                            logic [4:0] off);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (off)
            tcd_pkg::OFF_SEL:
            begin
                v[tcd_pkg::SEL_CAUSE_LSB +: 4] = s.cause[c];
                v[tcd_pkg::SEL_EXT_BIT]        = s.ext[c];
            end
            tcd_pkg::OFF_CTL:
            begin
                v[tcd_pkg::CTL_WORD_BIT]      = s.word[c];
                v[tcd_pkg::CTL_REP_BIT]       = s.rep[c];
                v[tcd_pkg::CTL_EN_BIT]        = s.en[c];
                v[tcd_pkg::CTL_MODE_LSB +: 2] = s.mode[c];
                v[tcd_pkg::CTL_DONE_BIT]      = s.done[c];
            end
            tcd_pkg::OFF_SRC: v[tcd_pkg::AW-1:0] = s.src[c];
            tcd_pkg::OFF_DST: v[tcd_pkg::AW-1:0] = s.dst[c];
            tcd_pkg::OFF_FWD: v[tcd_pkg::AW-1:0] = s.fwd[c];
            tcd_pkg::OFF_RLD: v[tcd_pkg::CW-1:0] = s.rld[c];
            tcd_pkg::OFF_CNT: v[tcd_pkg::CW-1:0] = s.cnt[c];
            default:          v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // external pins: two flops, then a third stage for edge detection
    assign int_fall = r.s3 & ~r.s2;
    assign int_both = r.s3 ^ r.s2;

    // one request latch per channel [R1]
    for (genvar g = 0; g < tcd_pkg::NCH; g++)
    begin : g_ch
        tcd_channel #(
            .CH          (1'(g)),
            .REDUCED_PKG (REDUCED_PKG)
        ) u_ch (
            .i_clk      (i_clk),
            .i_nrst     (i_nrst),
            .i_cause    (r.cause[g]),
            .i_ext      (r.ext[g]),
            .i_sw_req   (r.swreq[g]),
            .i_enable   (r.en[g]),
            .i_periph   (i_periph_irq),
            .i_int_fall (int_fall),
            .i_int_both (int_both),
            .i_taken    (taken[g]),
            .o_pending  (pend[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [31:0]            w;
        logic                   wch;
        logic                   c;
        logic [4:0]             off;
        logic [tcd_pkg::AW-1:0] f;
        next_r = r;
        taken  = 2'b00;
        w      = 32'h0000_0000;
        wch    = i_avs_address[tcd_pkg::ADDR_CH_BIT];
        off    = i_avs_address[4:0];
        c      = r.ch;
        f      = r.fwd[r.ch];

        next_r.s1    = {i_ext_irq_line_1, i_ext_irq_line_0};
        next_r.s2    = r.s1;
        next_r.s3    = r.s2;
        next_r.swreq = 2'b00;

        // answer one cycle after the request is seen
        next_r.wreq = !((i_avs_read || i_avs_write) && r.wreq);
        if (i_avs_read && r.wreq)
            next_r.rdata = reg_val(r, wch, off);
        if (i_avs_write && !r.wreq)
        begin
            w = reg_val(r, wch, off);
            for (int b = 0; b < 4; b++)
                if (i_avs_byteenable[b])
                    w[b*8 +: 8] = i_avs_writedata[b*8 +: 8];
            unique case (off)
                tcd_pkg::OFF_SEL:
                begin
                    next_r.cause[wch] = w[tcd_pkg::SEL_CAUSE_LSB +: 4];
                    next_r.ext[wch]   = w[tcd_pkg::SEL_EXT_BIT];
                    next_r.swreq[wch] = i_avs_byteenable[0] &&
                        i_avs_writedata[tcd_pkg::SEL_SWREQ_BIT];  // [R4]
                end
                tcd_pkg::OFF_CTL:
                begin
                    next_r.word[wch] = w[tcd_pkg::CTL_WORD_BIT];
                    next_r.rep[wch]  = w[tcd_pkg::CTL_REP_BIT];
                    next_r.en[wch]   = w[tcd_pkg::CTL_EN_BIT];
                    next_r.mode[wch] = w[tcd_pkg::CTL_MODE_LSB +: 2];
                    if (w[tcd_pkg::CTL_EN_BIT] && !r.en[wch])
                    begin
                        next_r.first[wch] = 1'b1;                   // [R17]
                        next_r.done[wch]  = 1'b0;
                    end
                end
                tcd_pkg::OFF_SRC: next_r.src[wch] = w[tcd_pkg::AW-1:0];
                tcd_pkg::OFF_DST: next_r.dst[wch] = w[tcd_pkg::AW-1:0];
                tcd_pkg::OFF_RLD: next_r.rld[wch] = w[tcd_pkg::CW-1:0];
                default:          next_r.rld = next_r.rld;
            endcase
        end

        ////////////////////////////////////////////////////////////////
        // cycle-steal engine; a request latched mid-transfer merges [R8]
        unique case (r.fsm)
            tcd_pkg::TCD_IDLE:
            begin
                if (pend != 2'b00)
                begin
                    c = !pend[0];                                   // [R13]
                    taken[c] = 1'b1;
                    f = r.fwd[c];
                    if (r.first[c])
                    begin
                        f = (r.mode[c] == tcd_pkg::MODE_DST_INC) ?
                            r.dst[c] : r.src[c];                    // [R17]
                        next_r.cnt[c]   = r.rld[c];
                        next_r.first[c] = 1'b0;
                        next_r.fwd[c]   = f;
                    end
                    next_r.ch       = c;
                    next_r.cpu_hold = 1'b1;                         // [R3]
                    next_r.mem_rd   = 1'b1;                        // [R20]
                    next_r.mem_word = r.word[c];                    // [R2]
                    next_r.mem_addr =
                        (r.mode[c] == tcd_pkg::MODE_SRC_INC) ?
                        f : r.src[c];                               // [R9]
                    next_r.fsm = tcd_pkg::TCD_READ;
                end
            end
            tcd_pkg::TCD_READ:
            begin
                if (!i_mem_wait)
                begin
                    next_r.mem_wdata = r.mem_word ? i_mem_rdata :
                        {8'h00, i_mem_rdata[7:0]};                  // [R2]
                    next_r.mem_rd   = 1'b0;
                    next_r.mem_wr   = 1'b1;                        // [R20]
                    next_r.mem_addr =
                        (r.mode[c] == tcd_pkg::MODE_DST_INC) ?
                        r.fwd[c] : r.dst[c];                        // [R9]
                    next_r.fsm = tcd_pkg::TCD_WRITE;
                end
            end
            tcd_pkg::TCD_WRITE:
            begin
                if (!i_mem_wait)
                begin
                    next_r.mem_wr   = 1'b0;
                    next_r.cpu_hold = 1'b0;
                    if (r.mode[c] == tcd_pkg::MODE_SRC_INC ||
                        r.mode[c] == tcd_pkg::MODE_DST_INC)
                        next_r.fwd[c] = r.fwd[c] +
                            (r.mem_word ? 20'h00002 : 20'h00001);   // [R21]
                    if (r.cnt[c] == tcd_pkg::RST_CNT)
                    begin
                        if (r.rep[c])
                            next_r.cnt[c] = r.rld[c];               // [R15]
                        else
                        begin
                            next_r.en[c]   = 1'b0;            // [R14] [R16]
                            next_r.done[c] = 1'b1;
                        end
                    end
                    else
                        next_r.cnt[c] = r.cnt[c] - 16'h0001;  // [R10] [R21]
                    next_r.fsm = tcd_pkg::TCD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            r       <= '0;
            r.cause <= {tcd_pkg::RST_CAUSE, tcd_pkg::RST_CAUSE};
            r.mode  <= {tcd_pkg::RST_MODE, tcd_pkg::RST_MODE};
            r.src   <= {tcd_pkg::RST_PTR, tcd_pkg::RST_PTR};
            r.dst   <= {tcd_pkg::RST_PTR, tcd_pkg::RST_PTR};
            r.fwd   <= {tcd_pkg::RST_PTR, tcd_pkg::RST_PTR};
            r.cnt   <= {tcd_pkg::RST_CNT, tcd_pkg::RST_CNT};
            r.rld   <= {tcd_pkg::RST_CNT, tcd_pkg::RST_CNT};
            r.fsm   <= tcd_pkg::TCD_IDLE;
            r.wreq  <= 1'b1;
            r.s1    <= tcd_pkg::RST_PINS;
            r.s2    <= tcd_pkg::RST_PINS;
            r.s3    <= tcd_pkg::RST_PINS;
        end
        else
            r <= next_r;
    end

    assign o_avs_readdata    = r.rdata;
    assign o_avs_waitrequest = r.wreq;
    assign o_cpu_hold        = r.cpu_hold;
    assign o_mem_addr        = r.mem_addr;
    assign o_mem_read        = r.mem_rd;
    assign o_mem_write       = r.mem_wr;
    assign o_mem_word        = r.mem_word;
    assign o_mem_wdata       = r.mem_wdata;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    logic wr_done0;
    logic bus_wr;
    assign bus_wr   = i_avs_write && !r.wreq;
    assign wr_done0 = r.fsm == tcd_pkg::TCD_WRITE && !i_mem_wait &&
                      !r.ch && !bus_wr;
    property p_prio;
        r.fsm == tcd_pkg::TCD_IDLE && pend == 2'b11 |=> !r.ch;
    endproperty
    a_prio: assert property (p_prio) else $error("ch1 served first"); // [R13]
    property p_start;
        r.fsm == tcd_pkg::TCD_IDLE && pend != 2'b00
            |=> o_mem_read && o_cpu_hold;
    endproperty
    a_start: assert property (p_start) else $error("no bus take"); // [R3]
    property p_hold;
        o_mem_read || o_mem_write |-> o_cpu_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("no hold"); // [R3]
    property p_rd_wr;
        o_mem_read && !i_mem_wait |=> o_mem_write && !o_mem_read && o_cpu_hold;
    endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("no write"); // [R20]
    property p_src_fixed;
        o_mem_read && r.mode[r.ch] == tcd_pkg::MODE_DST_INC
            |-> o_mem_addr == r.src[r.ch];
    endproperty
    a_src_fixed: assert property (p_src_fixed)                      // [R9]
        else $error("fixed source address moved");
    property p_step;
        r.fsm == tcd_pkg::TCD_WRITE && !i_mem_wait && r.mem_word &&
            (r.mode[r.ch] == tcd_pkg::MODE_SRC_INC ||
             r.mode[r.ch] == tcd_pkg::MODE_DST_INC)
            |=> r.fwd[r.ch] == $past(r.fwd[r.ch]) + 20'h00002;
    endproperty
    a_step: assert property (p_step) else $error("bad step"); // [R21]
    property p_dec;
        wr_done0 && r.cnt[0] != tcd_pkg::RST_CNT
            |=> r.cnt[0] == $past(r.cnt[0]) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("no decrement"); // [R10]
    property p_single_end;
        wr_done0 && r.cnt[0] == tcd_pkg::RST_CNT && !r.rep[0]
            |=> !r.en[0] && r.done[0];
    endproperty
    a_single_end: assert property (p_single_end)                   // [R14]
        else $error("single run did not stop on underflow");
    property p_repeat;
        wr_done0 && r.cnt[0] == tcd_pkg::RST_CNT && r.rep[0]
            |=> r.en[0] && r.cnt[0] == $past(r.rld[0]);
    endproperty
    a_repeat: assert property (p_repeat) else $error("no reload"); // [R15]
    property p_first;
        r.fsm == tcd_pkg::TCD_IDLE && pend[0] && r.first[0] && !bus_wr
            |=> r.cnt[0] == $past(r.rld[0]) && !r.first[0];
    endproperty
    a_first: assert property (p_first) else $error("no first reload"); // [R17]
    c_both: cover property (r.fsm == tcd_pkg::TCD_IDLE && pend == 2'b11);
    c_single: cover property (wr_done0 && !r.rep[0] &&
                              r.cnt[0] == tcd_pkg::RST_CNT);
    c_repeat: cover property (wr_done0 && r.rep[0] &&
                              r.cnt[0] == tcd_pkg::RST_CNT);

endmodule

//--- tcd_mem.sv
`timescale 1ns/1ns
module tcd_mem (
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    input  wire logic [19:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    output logic             o_wait,
    output int               o_cnt,
    output logic      [19:0] o_addr,
    output logic      [15:0] o_data
);
    logic        seen = 1'b0;
    int          n = 0;
    logic [15:0] pat;
    assign pat = i_addr[15:0] ^ 16'h5A3C;
    // slow bus stalls each access once; idle data line shows no stale value
    assign o_wait  = i_slow & (i_rd | i_wr) & ~seen;
    assign o_rdata = i_rd ? pat : ~pat;
    assign o_cnt = n;
    always @(posedge i_clk)
    begin
        seen <= (i_rd | i_wr) & o_wait;
        if (i_wr & ~o_wait)
        begin
            n      <= n + 1;
            o_addr <= i_addr;
            o_data <= i_wdata;
        end
    end
endmodule

//--- tcd_dma_test.sv
`timescale 1ns/1ns
module tcd_dma_test;
    logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
    logic        ex0 = 1'b1, slow = 1'b0, wq, hold, mrd, mwr, mwd1, mwt;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wd = 32'h0, rdat, v;
    logic [14:0] per = 15'h0;
    logic [19:0] maddr, la;
    logic [15:0] mwd, mrdat, ld;
    int          mcnt, failures = 0, check_count = 0;
    tcd_dma tcd_dma_i (.i_clk(clk), .i_nrst(nrst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .i_periph_irq(per),
        .i_ext_irq_line_0(ex0), .i_ext_irq_line_1(1'b1), .o_cpu_hold(hold),
        .o_mem_addr(maddr), .o_mem_read(mrd), .o_mem_write(mwr),
        .o_mem_word(mwd1), .o_mem_wdata(mwd), .i_mem_rdata(mrdat),
        .i_mem_wait(mwt));
    tcd_mem tcd_mem_i (.i_clk(clk), .i_slow(slow), .i_addr(maddr),
        .i_rd(mrd), .i_wr(mwr), .i_wdata(mwd), .o_rdata(mrdat),
        .o_wait(mwt), .o_cnt(mcnt), .o_addr(la), .o_data(ld));
    ////////////////////////////////////////////////////////////////////
    task test_done;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= ~w;
        do
            @(posedge clk);
        while (wq !== 1'b0);
        v = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task xfer(input int n, input logic [19:0] a, input logic [15:0] d);
        for (int i = 0; i < 40 && mcnt != n; i++)
            @(posedge clk);
        chk("count", n, mcnt);
        chk("dest", {12'h0, a}, {12'h0, la});
        chk("data", {16'h0, d}, {16'h0, ld});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        failures++;
        test_done();
    end
    // addresses stay clear of the controller's own register area
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, 6'h04, 32'h0);
        chk("ctl reset", 32'h0, v);
        bus(1'b0, 6'h1C, 32'h0);
        chk("unmapped", 32'h0, v);
        // ch0: byte, single, source counts up, three units
        bus(1'b1, 6'h08, 32'h100);
        bus(1'b1, 6'h0C, 32'h200);
        bus(1'b1, 6'h10, 32'h2);
        bus(1'b1, 6'h04, 32'h0C);
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b1, 6'h00, 32'h80);
            xfer(k + 1, 20'h200, 16'(k ^ 'h3C));
        end
        bus(1'b0, 6'h04, 32'h0);
        chk("ctl done", 32'h28, v);
        bus(1'b1, 6'h00, 32'h80);
        repeat (8) @(posedge clk);
        xfer(3, 20'h200, 16'h3E);
        // ch1: word, repeat, destination counts up, one unit a run
        slow <= 1'b1;
        bus(1'b1, 6'h28, 32'h300);
        bus(1'b1, 6'h2C, 32'h400);
        bus(1'b1, 6'h30, 32'h0);
        bus(1'b1, 6'h24, 32'h17);
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, 6'h20, 32'h80);
            xfer(k + 4, 20'('h400 + 2 * k), 16'h593C);
        end
        bus(1'b0, 6'h24, 32'h0);
        chk("ctl repeat", 32'h17, v);
        // both channels on one timer cause, then pin edges and a serial cause
        bus(1'b1, 6'h0C, 32'h500);
        bus(1'b1, 6'h04, 32'h07);
        bus(1'b1, 6'h00, 32'h02);
        bus(1'b1, 6'h20, 32'h02);
        per <= 15'h1;
        @(posedge clk);
        per <= 15'h0;
        bus(1'b1, 6'h20, 32'h82);
        xfer(6, 20'h500, 16'h5B3C);
        xfer(7, 20'h404, 16'h593C);
        bus(1'b1, 6'h00, 32'h01);
        ex0 <= 1'b0;
        xfer(8, 20'h500, 16'h5B3C);
        bus(1'b1, 6'h00, 32'h41);
        ex0 <= 1'b1;
        xfer(9, 20'h500, 16'h5B3C);
        bus(1'b1, 6'h20, 32'h0A);
        per <= 15'h200;
        @(posedge clk);
        per <= 15'h0;
        xfer(10, 20'h406, 16'h593C);
        test_done();
    end
endmodule
